// [rtl/bst_pkg.sv]
// package: tap states, instruction codes, reset values and carrier structs
package bst_pkg;

   localparam int unsigned IR_WIDTH = 8;
   // value loaded into the instruction register in capture-ir
   localparam logic [7:0] IR_CAPTURE_VAL = 8'h81;
   // all-ones instruction selects bypass
   localparam logic [7:0] IR_BYPASS      = 8'hff;
   // instruction after test-logic-reset
   localparam logic [7:0] IR_RESET_VAL   = 8'hff;
   // value captured into bypass in capture-dr
   localparam logic       BYP_CAPTURE_VAL = 1'b0;
   // number of flops in each input synchroniser
   localparam int unsigned SYNC_STAGES = 2;

   typedef enum logic [3:0] {
      TAP_RESET,
      TAP_IDLE,
      TAP_SEL_DR,
      TAP_CAP_DR,
      TAP_SH_DR,
      TAP_EX1_DR,
      TAP_PAU_DR,
      TAP_EX2_DR,
      TAP_UPD_DR,
      TAP_SEL_IR,
      TAP_CAP_IR,
      TAP_SH_IR,
      TAP_EX1_IR,
      TAP_PAU_IR,
      TAP_EX2_IR,
      TAP_UPD_IR
   } bst_tap_e;

   // pins from the test controller
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bst_link_in_s;

   // serial output pin, three-state as output plus enable
   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } bst_link_out_s;

endpackage : bst_pkg

// [rtl/bst_sync.sv]
// two-flop synchroniser for one asynchronous input level
module bst_sync
   import bst_pkg::*;
#(
   parameter int unsigned STAGES = SYNC_STAGES
) (
   // clock and reset
   input  wire logic clock_in,
   input  wire logic srst_in,
   // level in and out
   input  wire logic async_in,
   output logic      sync_out
);

   // a single flop would let a metastable level reach the edge detector
   if (STAGES < 2) begin : g_bad_stages
      $error("bst_sync needs at least two stages");
   end

   logic [STAGES-1:0] chain_q;

   always_ff @(posedge clock_in) begin
      if (srst_in) chain_q <= '0;
      else         chain_q <= {chain_q[STAGES-2:0], async_in};
   end

   assign sync_out = chain_q[STAGES-1];

endmodule // bst_sync

// [rtl/bst_tap.sv]
// test access port: tap state machine, instruction and bypass registers
// Contract
// R01: all test logic advances only on detected test clock edges; bypass_sel_q instead reloads from ir_act_q on every system clock.
// R02: tdi, tms and function inputs are sampled on test clock rising edges.
// R03: tdo and test-driven function outputs change only on test clock falling edges.
// R04: controller changes tms on falling edge; rising edge advances tap one state.
// R05: from reset, tms 0 reaches idle, then select-dr, select-ir, capture-ir, shift-ir.
// R06: instruction register is 8 bits, captures 10000001 leaving capture-ir.
// R07: in shift-ir one tdi bit enters per rising edge, old bits exit on tdo.
// R08: shifting in 11111111 then updating selects bypass.
// R09: last instruction bit shifts on the edge moving shift-ir to exit1-ir.
// R10: tdo starts driving on the falling edge after entering a shift state.
// R11: tdo goes high-impedance on the falling edge after entering exit1.
// R12: in update-ir the active instruction loads on the falling edge.
// R13: when selected, bypass loads 0 on the edge leaving capture-dr.
// R14: bypass is one-stage delay; 101 in gives 010 out.
// R15: in update-dr the selected data register updates on the falling edge.
// R16: first serial bit enters the scan path on the edge leaving capture.
// R17: all other transitions follow the 16-state diagram; five tms-high clocks reset.
module bst_tap
   import bst_pkg::*;
#(
   parameter int unsigned FUNC_WIDTH = 1
) (
   // system clock and reset
   input  wire logic                  clock_in,
   input  wire logic                  srst_in,
   // test link pins
   input  wire bst_link_in_s          link_in,
   output bst_link_out_s              link_out,
   // normal-function inputs sampled by test logic
   input  wire logic [FUNC_WIDTH-1:0] func_in,
   // normal-function outputs driven by test logic
   output logic [FUNC_WIDTH-1:0]      func_out,
   // status
   output bst_tap_e                   tap_state_out,
   output logic [IR_WIDTH-1:0]        instr_out,
   output logic                       bypass_sel_out
);

   // a zero-width function port has nothing to synchronise or sample
   if (FUNC_WIDTH < 1) begin : g_bad_width
      $error("bst_tap needs FUNC_WIDTH of at least one");
   end

   // synchronised pins; each first flop is read only by its second
   logic                  tck_s;
   logic                  tms_s;
   logic                  tdi_s;
   logic [FUNC_WIDTH-1:0] func_s;

   bst_sync u_sync_tck (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .async_in (link_in.tck),
      .sync_out (tck_s)
   );
   bst_sync u_sync_tms (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .async_in (link_in.tms),
      .sync_out (tms_s)
   );
   bst_sync u_sync_tdi (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .async_in (link_in.tdi),
      .sync_out (tdi_s)
   );

   genvar gi;
   generate
      for (gi = 0; gi < FUNC_WIDTH; gi++) begin : g_func_sync
         bst_sync u_sync_func (
            .clock_in (clock_in),
            .srst_in  (srst_in),
            .async_in (func_in[gi]),
            .sync_out (func_s[gi])
         );
      end
   endgenerate

   // limitation: a tck phase shorter than one system clock can be lost; tms and tdi
   // pass the same sync depth as tck, so they line up with the detected edge
   // test clock edge detection
   logic tck_prev_q;
   always_ff @(posedge clock_in) begin
      if (srst_in) tck_prev_q <= 1'b0;
      else         tck_prev_q <= tck_s;
   end

   // R01 edges only
   wire tck_rise = tck_s & ~tck_prev_q;
   wire tck_fall = ~tck_s & tck_prev_q;

   // tap state machine
   bst_tap_e state_q;
   bst_tap_e state_d;

   // R17 standard diagram
   always_comb begin
      state_d = TAP_RESET;
      case (state_q)
         TAP_RESET: begin
            if (tms_s) state_d = TAP_RESET;
            else       state_d = TAP_IDLE;
         end

         TAP_IDLE: begin
            if (tms_s) state_d = TAP_SEL_DR;
            else       state_d = TAP_IDLE;
         end

         TAP_SEL_DR: begin
            if (tms_s) state_d = TAP_SEL_IR;
            else       state_d = TAP_CAP_DR;
         end

         TAP_CAP_DR: begin
            if (tms_s) state_d = TAP_EX1_DR;
            else       state_d = TAP_SH_DR;
         end

         TAP_SH_DR: begin
            if (tms_s) state_d = TAP_EX1_DR;
            else       state_d = TAP_SH_DR;
         end

         TAP_EX1_DR: begin
            if (tms_s) state_d = TAP_UPD_DR;
            else       state_d = TAP_PAU_DR;
         end

         TAP_PAU_DR: begin
            if (tms_s) state_d = TAP_EX2_DR;
            else       state_d = TAP_PAU_DR;
         end

         TAP_EX2_DR: begin
            if (tms_s) state_d = TAP_UPD_DR;
            else       state_d = TAP_SH_DR;
         end

         TAP_UPD_DR: begin
            if (tms_s) state_d = TAP_SEL_DR;
            else       state_d = TAP_IDLE;
         end

         TAP_SEL_IR: begin
            if (tms_s) state_d = TAP_RESET;
            else       state_d = TAP_CAP_IR;
         end

         TAP_CAP_IR: begin
            if (tms_s) state_d = TAP_EX1_IR;
            else       state_d = TAP_SH_IR;
         end

         TAP_SH_IR: begin
            if (tms_s) state_d = TAP_EX1_IR;
            else       state_d = TAP_SH_IR;
         end

         TAP_EX1_IR: begin
            if (tms_s) state_d = TAP_UPD_IR;
            else       state_d = TAP_PAU_IR;
         end

         TAP_PAU_IR: begin
            if (tms_s) state_d = TAP_EX2_IR;
            else       state_d = TAP_PAU_IR;
         end

         TAP_EX2_IR: begin
            if (tms_s) state_d = TAP_UPD_IR;
            else       state_d = TAP_SH_IR;
         end

         TAP_UPD_IR: begin
            if (tms_s) state_d = TAP_SEL_DR;
            else       state_d = TAP_IDLE;
         end

         default: begin
            // unreachable codes recover through test-logic-reset
            state_d = TAP_RESET;
         end
      endcase
   end

   // R04 one state per rising edge
   // R05 path from reset to shift-ir
   always_ff @(posedge clock_in) begin
      if (srst_in)       state_q <= TAP_RESET;
      else if (tck_rise) state_q <= state_d;
   end

   // decoded states
   wire in_cap_ir = (state_q == TAP_CAP_IR);
   wire in_sh_ir  = (state_q == TAP_SH_IR);
   wire in_upd_ir = (state_q == TAP_UPD_IR);
   wire in_cap_dr = (state_q == TAP_CAP_DR);
   wire in_sh_dr  = (state_q == TAP_SH_DR);
   wire in_upd_dr = (state_q == TAP_UPD_DR);
   wire in_reset  = (state_q == TAP_RESET);
   wire in_shift  = in_sh_ir | in_sh_dr;

   // qualified strobes: each register moves on one test clock edge only,
   // though ir_act_q and tdo_q move in two states each, so no register can move on both edges
   wire upd_ir_fall = tck_fall & in_upd_ir;
   wire upd_dr_fall = tck_fall & in_upd_dr;
   wire reset_fall  = tck_fall & in_reset;
   wire shift_fall  = tck_fall & in_shift;

   // instruction shift register and active instruction
   logic [IR_WIDTH-1:0] ir_sh_q;
   logic [IR_WIDTH-1:0] ir_act_q;

   // R06 capture fixed pattern
   // R07 shift lsb first toward tdo
   // R09 last bit shifts on exit edge
   // R16 first bit leaves capture
   wire [IR_WIDTH-1:0] ir_shifted = {tdi_s, ir_sh_q[IR_WIDTH-1:1]};
   wire [IR_WIDTH-1:0] ir_sh_d    = in_cap_ir ? IR_CAPTURE_VAL :
                                    in_sh_ir  ? ir_shifted : ir_sh_q;

   // R02 sample on rising edge
   always_ff @(posedge clock_in) begin
      if (srst_in)       ir_sh_q <= IR_CAPTURE_VAL;
      else if (tck_rise) ir_sh_q <= ir_sh_d;
   end

   // R12 update on falling edge
   // R08 all ones becomes bypass
   always_ff @(posedge clock_in) begin
      if (srst_in)                    ir_act_q <= IR_RESET_VAL;
      else if (reset_fall)            ir_act_q <= IR_RESET_VAL;
      else if (upd_ir_fall)           ir_act_q <= ir_sh_q;
   end

   // other instructions have no register in this block, so every data scan goes through bypass

   // bypass register
   logic byp_q;

   // R13 capture zero
   // R14 single-stage delay
   wire byp_d = in_cap_dr ? BYP_CAPTURE_VAL : in_sh_dr ? tdi_s : byp_q;

   always_ff @(posedge clock_in) begin
      if (srst_in)                  byp_q <= BYP_CAPTURE_VAL;
      else if (tck_rise)            byp_q <= byp_d;
   end

   // function inputs are sampled on rising edges, outputs follow on falling edges
   logic [FUNC_WIDTH-1:0] func_smp_q;
   logic [FUNC_WIDTH-1:0] func_out_q;

   always_ff @(posedge clock_in) begin
      if (srst_in)       func_smp_q <= '0;
      else if (tck_rise) func_smp_q <= func_s;
   end

   // R15 update-dr on falling edge
   // R03 outputs move on falling edge
   always_ff @(posedge clock_in) begin
      if (srst_in)                    func_out_q <= '0;
      else if (upd_dr_fall)           func_out_q <= func_smp_q;
   end

   // serial output
   wire tdo_bit = in_sh_ir ? ir_sh_q[0] : byp_q;
   logic tdo_q;
   logic tdo_oe_q;

   // R10 drive after shift entry
   // R03 tdo moves on falling edge
   always_ff @(posedge clock_in) begin
      if (srst_in)         tdo_q <= 1'b0;
      else if (shift_fall) tdo_q <= tdo_bit;
   end

   // R11 float after exit1
   // oe follows the state seen at each fall, so pause states float too
   always_ff @(posedge clock_in) begin
      if (srst_in)       tdo_oe_q <= 1'b0;
      else if (tck_fall) tdo_oe_q <= in_shift;
   end

   // outputs, each from a flop
   logic bypass_sel_q;
   always_ff @(posedge clock_in) begin
      if (srst_in) bypass_sel_q <= 1'b1;
      else         bypass_sel_q <= (ir_act_q == IR_BYPASS);
   end

   assign link_out.tdo    = tdo_q;
   assign link_out.tdo_oe = tdo_oe_q;
   assign func_out        = func_out_q;
   assign tap_state_out   = state_q;
   assign instr_out       = ir_act_q;
   assign bypass_sel_out  = bypass_sel_q;

endmodule // bst_tap

// [bench/bst_tap_assertions.sv]
// port checks for the tap block
module bst_tap_assertions
   import bst_pkg::*;
#(
   parameter int unsigned FUNC_WIDTH = 1
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // link pins and outputs
   input wire bst_link_in_s link_in,
   input wire bst_link_out_s link_out,
   input wire logic [FUNC_WIDTH-1:0] func_out,
   input wire bst_tap_e tap_state_out,
   input wire logic [IR_WIDTH-1:0] instr_out,
   input wire logic bypass_sel_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);
   sequence ir_entry;
      $past(tap_state_out) == TAP_CAP_IR && tap_state_out == TAP_SH_IR;
   endsequence
   sequence dr_entry;
      $past(tap_state_out) == TAP_CAP_DR && tap_state_out == TAP_SH_DR;
   endsequence
   tdo_on_fall_a: assert property ($changed(link_out) |-> !link_in.tck)
      else $error("tdo moved with tck high");
   state_on_rise_a: assert property ($changed(tap_state_out) |-> link_in.tck)
      else $error("state moved with tck low");
   instr_update_a: assert property ($changed(instr_out) |->
      !link_in.tck && tap_state_out inside {TAP_UPD_IR, TAP_RESET})
      else $error("instr moved outside update");
   bypass_select_a: assert property (bypass_sel_out == ($past(instr_out) == IR_BYPASS))
      else $error("bypass select wrong");
   oe_rise_shift_a: assert property ($rose(link_out.tdo_oe) |-> tap_state_out inside {TAP_SH_IR, TAP_SH_DR})
      else $error("tdo enabled outside shift");
   oe_fall_exit_a: assert property ($fell(link_out.tdo_oe) |-> tap_state_out inside {TAP_EX1_IR, TAP_EX1_DR})
      else $error("tdo released outside exit1");
   ir_capture_a: assert property (ir_entry |-> ##[1:12] link_out.tdo_oe && link_out.tdo == IR_CAPTURE_VAL[0])
      else $error("ir capture bit wrong");
   byp_capture_a: assert property (dr_entry |-> ##[1:12] link_out.tdo_oe && link_out.tdo == BYP_CAPTURE_VAL)
      else $error("bypass capture bit wrong");
   func_update_a: assert property ($changed(func_out) |-> !link_in.tck && tap_state_out == TAP_UPD_DR)
      else $error("function output moved outside update");
   exit_ir_next_a: assert property ($changed(tap_state_out) && $past(tap_state_out) == TAP_EX1_IR
      |-> tap_state_out inside {TAP_PAU_IR, TAP_UPD_IR})
      else $error("bad exit1 transition");
   reset_reload_a: assert property (tap_state_out == TAP_RESET && $fell(link_in.tck)
      |-> ##[1:6] instr_out == IR_RESET_VAL)
      else $error("instr not reloaded in reset");
endmodule // bst_tap_assertions

// [bench/bst_ctrl_model.sv]
// test controller model driving the link pins
module bst_ctrl_model
   import bst_pkg::*;
(
   // pins towards and from the block
   output bst_link_in_s link_out,
   input wire bst_link_out_s link_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // tck rests low between frames
   initial link_out = '0;
   task automatic cyc(input logic ms, input logic di, output bst_link_out_s seen);
      link_out.tms = ms;
      link_out.tdi = di;
      #62.5;
      seen = link_in;
      link_out.tck = 1'b1;
      #62.5;
      link_out.tck = 1'b0;
   endtask
endmodule // bst_ctrl_model

// [bench/bst_tap_tb_top.sv]
// self-checking bench for the tap block
module bst_tap_tb_top
   import bst_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_in, srst_in, bypass_sel_out;
   logic [0:0] func_in, func_out;
   logic [7:0] instr_out, v;
   bst_link_in_s link_in;
   bst_link_out_s link_out, seen;
   bst_tap_e tap_state_out, exp_st;
   int err_count, samples_checked;
   bst_tap #(.FUNC_WIDTH(1)) uut (.clock_in(clock_in), .srst_in(srst_in), .link_in(link_in),
      .link_out(link_out), .func_in(func_in), .func_out(func_out), .tap_state_out(tap_state_out),
      .instr_out(instr_out), .bypass_sel_out(bypass_sel_out));
   bst_ctrl_model ctl (.link_out(link_in), .link_in(link_out));
   function automatic bst_tap_e nxt(bst_tap_e s, logic m);
      case (s)
         TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
         TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_SEL_IR: return m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_DR, TAP_SH_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR, TAP_EX2_DR: return m ? TAP_UPD_DR : (s == TAP_EX1_DR ? TAP_PAU_DR : TAP_SH_DR);
         TAP_PAU_DR: return m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_CAP_IR, TAP_SH_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR, TAP_EX2_IR: return m ? TAP_UPD_IR : (s == TAP_EX1_IR ? TAP_PAU_IR : TAP_SH_IR);
         TAP_PAU_IR: return m ? TAP_EX2_IR : TAP_PAU_IR;
         default: return m ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction
   task automatic chk(input logic [7:0] got, exp, input string nm);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic t(input logic ms, input logic di);
      ctl.cyc(ms, di, seen);
      exp_st = nxt(exp_st, ms);
      chk(tap_state_out, exp_st, "state");
   endtask
   // seen holds tdo as left by the previous fall
   task automatic scan(input int n, input logic [7:0] di, exp);
      for (int i = 0; i < n; i++) begin
         t(i == n - 1, di[i]);
         chk(seen.tdo, exp[i], "tdo");
         chk(seen.tdo_oe, 1'b1, "tdo_oe");
      end
   endtask
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial begin
      #50us;
      err_count++;
      end_sim;
   end
   initial begin
      srst_in = 1'b1;
      func_in = '0;
      err_count = 0;
      samples_checked = 0;
      exp_st = TAP_RESET;
      v = 8'($urandom(44171));
      repeat (3) @(posedge clock_in);
      @(negedge clock_in) srst_in = 1'b0;
      // off-grid start keeps tck edges clear of clock edges
      #1;
      chk(instr_out, IR_RESET_VAL, "instr");
      chk(link_out.tdo_oe, 1'b0, "tdo_oe");
      t(1'b0, 1'b0);
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
         t(1'b1, 1'b0);
         t(1'b1, 1'b0);
         t(1'b0, 1'b0);
         t(1'b0, 1'b0);
         scan(8, v, IR_CAPTURE_VAL);
         t(1'b1, 1'b0);
         chk(seen.tdo_oe, 1'b0, "tdo_oe");
         t(1'b1, 1'b0);
         chk(instr_out, v, "instr");
         chk(bypass_sel_out, v == IR_BYPASS, "bypass_sel");
         func_in = 1'($urandom);
         t(1'b0, 1'b0);
         t(1'b0, 1'b0);
         scan(3, 8'h05, 8'h02);
         t(1'b1, 1'b0);
         chk(seen.tdo_oe, 1'b0, "tdo_oe");
         t(1'b0, 1'b0);
         chk(func_out, func_in, "func_out");
      end
      repeat (40) t(1'($urandom), 1'($urandom));
      repeat (6) t(1'b1, 1'b0);
      chk(tap_state_out, TAP_RESET, "state");
      chk(instr_out, IR_RESET_VAL, "instr");
      repeat (20) t(1'($urandom), 1'($urandom));
      srst_in = 1'b1;
      #40;
      srst_in = 1'b0;
      exp_st = TAP_RESET;
      chk(tap_state_out, TAP_RESET, "state");
      t(1'b0, 1'b0);
      end_sim;
   end
endmodule // bst_tap_tb_top
bind bst_tap bst_tap_assertions #(.FUNC_WIDTH(FUNC_WIDTH)) chk_i (.clock_in(clock_in), .srst_in(srst_in),
   .link_in(link_in), .link_out(link_out), .func_out(func_out), .tap_state_out(tap_state_out),
   .instr_out(instr_out), .bypass_sel_out(bypass_sel_out));
